// File: cvpi_interpreter.sv
// Config_variable programming interpreter, top module
// Function
// - Each variable holds one byte, 0 to 255
// - Accept direct, register, paged and main modes
// - Main: own address only, no read-back
// - Service track executes unaddressed writes
// - Bits numbered 0 lsb to 7 msb
// - Keypad procedure is write only
// - Enter keypad mode via address, direction, power
// - Entry 80 means value zero
// - Short mode: number and value below 80
// - Short mode awaiting number: brief periodic flash
// - Confirmed number: quick double flash, await value
// - Confirmed value: store, steady light, next number
// - Short mode exits on 80 or power cycle
// - Value 07 into 07 selects long mode
// - First long entry: number hundreds, tens
// - Second long entry: number units
// - Third long entry: value hundreds, tens
// - Fourth entry: write, light, stay long
// - Long mode ends only on power cycle
`timescale 1ns/10ps
`include "cvpi_regs.svh"

module cvpi_interpreter #(
  parameter int unsigned TICK_CYC = `CVPI_TICK_CYC
) (
  input wire logic clock, // Core clock, 250 MHz
  input wire logic rst_n, // Async reset, active low
  input wire logic track_power, // Track voltage present, pin
  input wire logic [13:0] own_addr, // Own locomotive address
  input wire logic dcc_valid, // Decoded track command pulse
  input wire cvpi_pkg::cvpi_dmode_t dcc_mode, // Programming mode
  input wire cvpi_pkg::cvpi_dcmd_t dcc_cmd, // Command kind
  input wire logic [13:0] dcc_addr, // Address of main commands
  input wire logic [9:0] dcc_num, // Variable or register number
  input wire logic [7:0] dcc_data, // Byte operand
  input wire logic [2:0] dcc_bit_pos, // Bit position
  input wire logic dcc_bit_val, // Bit operand
  input wire logic kp_word_valid, // Keypad entry pulse
  input wire logic [6:0] kp_word, // Keypad entry 1 to 80
  input wire logic kp_dir_held, // Direction change held level
  input wire logic kp_dir_change, // Direction change pulse
  input wire logic [7:0] cv_rd_data, // Store data, one cycle late
  output logic cv_wr_en, // Store write pulse
  output logic [9:0] cv_wr_num, // Store write number
  output logic [7:0] cv_wr_data, // Store write byte
  output logic cv_rd_en, // Store read pulse
  output logic [9:0] cv_rd_num, // Store read number
  output logic svc_ack, // Service acknowledge pulse
  output logic kp_active, // Keypad programming level
  output logic lamp // Headlight drive
);
  import cvpi_pkg::*;

  // ========================================================
  // State
  typedef struct packed {
    logic pwr_s1;
    logic pwr_s2;
    logic pwr_q;
    cvpi_kp_t kp;
    logic armed;
    logic pend;
    logic [6:0] word;
    logic ret_long;
    logic [9:0] num;
    logic [6:0] ht;
    cvpi_flash_t pat;
    logic restart;
    logic [7:0] page;
    logic busy;
    cvpi_dcmd_t cmd;
    logic svc;
    logic [2:0] bpos;
    logic bval;
    logic [7:0] data;
    logic wr_en;
    logic [9:0] wr_num;
    logic [7:0] wr_data;
    logic rd_en;
    logic [9:0] rd_num;
    logic ack;
    logic active;
  } cvpi_st_t;

  cvpi_st_t s_q, s_d;
  logic [6:0] kp_val;
  logic [9:0] asm_val;
  logic [9:0] tr_num;
  logic tr_ok;
  logic fl_done;
  logic fl_lamp_q;
  logic pwr_rise;
  logic pwr_fall;
  logic confirm;
  logic [7:0] bit_upd;

  // ========================================================
  // Lamp pattern generator
  cvpi_flash #(
    .TICK_CYC(TICK_CYC)
  ) u_flash (
    .clock(clock),
    .rst_n(rst_n),
    .pattern(s_q.pat),
    .restart(s_q.restart),
    .lamp(fl_lamp_q),
    .done(fl_done)
  );

  // ========================================================
  // Keypad decode helpers
  // entry 80 read as zero
  assign kp_val = (s_q.word == `CVPI_ENTRY_ZERO) ? 7'h00 : s_q.word;
  // Tens part times ten plus units
  assign asm_val = 10'(s_q.ht) * `CVPI_TEN + 10'(kp_val);
  assign pwr_rise = s_q.pwr_s2 && !s_q.pwr_q;
  assign pwr_fall = !s_q.pwr_s2 && s_q.pwr_q;
  assign confirm = kp_dir_change && s_q.pend;

  // ========================================================
  // Register and paged number translation
  // service register and page mapping
  always_comb begin
    tr_ok = 1'b1;
    tr_num = dcc_num;
    if (dcc_mode == CVPI_DM_REGISTER || dcc_mode == CVPI_DM_PAGED) begin
      unique case (dcc_num[2:0])
        3'h0, 3'h1, 3'h2, 3'h3: begin
          if (dcc_mode == CVPI_DM_PAGED) begin
            tr_num = {s_q.page[7:0] - 8'h01, dcc_num[1:0]} + 10'h001;
          end else begin
            tr_num = {8'h00, dcc_num[1:0]} + 10'h001;
          end
        end
        `CVPI_REG_CV29: tr_num = `CVPI_CV29;
        `CVPI_REG_PAGE: tr_ok = 1'b0;
        3'h6, 3'h7: tr_num = {7'h00, dcc_num[2:0]} + 10'h001;
      endcase
    end
  end

  // bit 0 is lsb, bit 7 msb
  always_comb begin
    bit_upd = cv_rd_data;
    bit_upd[s_q.bpos] = s_q.bval;
  end

  // ========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.pwr_s1 = track_power;
    s_d.pwr_s2 = s_q.pwr_s1;
    s_d.pwr_q = s_q.pwr_s2;
    s_d.wr_en = 1'b0;
    s_d.rd_en = 1'b0;
    s_d.ack = 1'b0;
    s_d.restart = 1'b0;
    // A confirmation consumes the entry; a new entry wins
    if (confirm) begin
      s_d.pend = 1'b0;
    end
    if (kp_word_valid) begin
      s_d.word = kp_word;
      s_d.pend = 1'b1;
    end

    if (pwr_fall) begin
      s_d.kp = CVPI_KP_NORMAL;
      s_d.pat = CVPI_FL_OFF;
      s_d.restart = 1'b1;
      s_d.pend = 1'b0;
      s_d.busy = 1'b0;
    end else if (pwr_rise) begin
      if (s_q.armed) begin
        s_d.kp = CVPI_KP_S_NUM;
        s_d.pat = CVPI_FL_SHORT;
        s_d.restart = 1'b1;
        s_d.ret_long = 1'b0;
      end
      s_d.armed = 1'b0;
      s_d.pend = 1'b0;
    end else if (s_q.kp == CVPI_KP_NORMAL) begin
      // own address or 80 with direction held
      if (kp_word_valid && kp_dir_held &&
          (kp_word == own_addr[6:0] ||
           kp_word == `CVPI_ENTRY_ZERO)) begin
        s_d.armed = 1'b1;
      end
      // Track programming pipeline
      if (s_q.busy && !s_q.rd_en) begin // Wait for store data
        s_d.busy = 1'b0;
        unique case (s_q.cmd)
          CVPI_DC_VFY_BYTE: s_d.ack = (cv_rd_data == s_q.data);
          CVPI_DC_VFY_BIT: s_d.ack = (cv_rd_data[s_q.bpos] == s_q.bval);
          CVPI_DC_WR_BIT: begin
            s_d.wr_en = 1'b1;
            s_d.wr_num = s_q.rd_num;
            s_d.wr_data = bit_upd;
            s_d.ack = s_q.svc;
          end
          CVPI_DC_WR_BYTE: s_d.ack = 1'b0;
        endcase
      end else if (dcc_valid && !s_q.busy) begin
        s_d.svc = (dcc_mode != CVPI_DM_MAIN);
        s_d.cmd = dcc_cmd;
        s_d.bpos = dcc_bit_pos;
        s_d.bval = dcc_bit_val;
        s_d.data = dcc_data;
        if (dcc_mode == CVPI_DM_MAIN) begin
          if (dcc_addr == own_addr) begin
            if (dcc_cmd == CVPI_DC_WR_BYTE) begin
              s_d.wr_en = 1'b1;
              s_d.wr_num = dcc_num;
              s_d.wr_data = dcc_data;
            end else if (dcc_cmd == CVPI_DC_WR_BIT) begin
              s_d.rd_en = 1'b1;
              s_d.rd_num = dcc_num;
              s_d.busy = 1'b1;
            end
          end
        end else if (dcc_mode != CVPI_DM_DIRECT &&
                     dcc_cmd[1]) begin
          // Register and paged modes carry bytes only
          s_d.ack = 1'b0;
        end else if (!tr_ok) begin
          // Page register access
          if (dcc_cmd == CVPI_DC_WR_BYTE) begin
            s_d.page = dcc_data;
            s_d.ack = 1'b1;
          end else begin
            s_d.ack = (s_q.page == dcc_data);
          end
        end else if (dcc_cmd == CVPI_DC_WR_BYTE) begin
          s_d.wr_en = 1'b1;
          s_d.wr_num = tr_num;
          s_d.wr_data = dcc_data;
          s_d.ack = 1'b1;
        end else begin
          s_d.rd_en = 1'b1;
          s_d.rd_num = tr_num;
          s_d.busy = 1'b1;
        end
      end
    end else if (s_q.kp == CVPI_KP_SHOW) begin
      // after the steady light, next number
      if (fl_done) begin
        s_d.restart = 1'b1;
        if (s_q.ret_long) begin
          s_d.kp = CVPI_KP_L_NHI;
          s_d.pat = CVPI_FL_SLOW;
        end else begin
          s_d.kp = CVPI_KP_S_NUM;
          s_d.pat = CVPI_FL_SHORT;
        end
      end
    end else if (confirm) begin
      unique case (s_q.kp)
        CVPI_KP_S_NUM: begin
          if (s_q.word == `CVPI_ENTRY_ZERO) begin
            s_d.kp = CVPI_KP_NORMAL;
            s_d.pat = CVPI_FL_OFF;
            s_d.restart = 1'b1;
          end else if (s_q.word < `CVPI_SHORT_LIM) begin
            s_d.num = 10'(s_q.word);
            s_d.kp = CVPI_KP_S_VAL;
            s_d.pat = CVPI_FL_DOUBLE;
            s_d.restart = 1'b1;
          end
        end
        CVPI_KP_S_VAL: begin
          if (kp_val < `CVPI_SHORT_LIM) begin
            s_d.restart = 1'b1;
            // 07 into 07 selects long mode
            if (s_q.num == `CVPI_LONG_KEY_NUM &&
                8'(kp_val) == `CVPI_LONG_KEY_VAL) begin
              s_d.kp = CVPI_KP_L_NHI;
              s_d.pat = CVPI_FL_SLOW;
            end else begin
              s_d.wr_en = 1'b1;
              s_d.wr_num = s_q.num;
              s_d.wr_data = 8'(kp_val);
              s_d.kp = CVPI_KP_SHOW;
              s_d.pat = CVPI_FL_STEADY;
              s_d.ret_long = 1'b0;
            end
          end
        end
        CVPI_KP_L_NHI: begin
          if (kp_val <= `CVPI_HT_MAX) begin
            s_d.ht = kp_val;
            s_d.kp = CVPI_KP_L_NLO;
            s_d.pat = CVPI_FL_LS;
            s_d.restart = 1'b1;
          end
        end
        CVPI_KP_L_NLO: begin
          if (kp_val <= `CVPI_UNIT_MAX) begin
            s_d.num = asm_val;
            s_d.kp = CVPI_KP_L_VHI;
            s_d.pat = CVPI_FL_LSS;
            s_d.restart = 1'b1;
          end
        end
        CVPI_KP_L_VHI: begin
          if (kp_val <= `CVPI_HT_MAX) begin
            s_d.ht = kp_val;
            s_d.kp = CVPI_KP_L_VLO;
            s_d.pat = CVPI_FL_LSSS;
            s_d.restart = 1'b1;
          end
        end
        CVPI_KP_L_VLO: begin
          // write, light, stay in long mode
          if (kp_val <= `CVPI_UNIT_MAX &&
              asm_val <= `CVPI_VAL_MAX) begin
            s_d.wr_en = 1'b1;
            s_d.wr_num = s_q.num;
            s_d.wr_data = asm_val[7:0];
            s_d.kp = CVPI_KP_SHOW;
            s_d.pat = CVPI_FL_STEADY;
            s_d.ret_long = 1'b1;
            s_d.restart = 1'b1;
          end
        end
        default: s_d.kp = s_q.kp;
      endcase
    end
    s_d.active = (s_d.kp != CVPI_KP_NORMAL);
  end

  // ========================================================
  // State register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.page <= `CVPI_PAGE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs from flops
  assign cv_wr_en = s_q.wr_en;
  assign cv_wr_num = s_q.wr_num;
  assign cv_wr_data = s_q.wr_data;
  assign cv_rd_en = s_q.rd_en;
  assign cv_rd_num = s_q.rd_num;
  assign svc_ack = s_q.ack;
  assign kp_active = s_q.active;
  assign lamp = fl_lamp_q;
endmodule

// File: cvpi_regs.svh
// Constants of the config_variable programming interpreter
`ifndef CVPI_REGS_SVH
`define CVPI_REGS_SVH

// ==========================================================
// Timing
`define CVPI_CLK_NS 4
`define CVPI_TICK_NS 62500000
`define CVPI_TICK_CYC (`CVPI_TICK_NS / `CVPI_CLK_NS)

// ==========================================================
// Keypad entry limits
`define CVPI_ENTRY_ZERO 7'h50
`define CVPI_SHORT_LIM 7'h50
`define CVPI_LONG_KEY_NUM 10'h007
`define CVPI_LONG_KEY_VAL 8'h07
`define CVPI_HT_MAX 7'h63
`define CVPI_UNIT_MAX 7'h09
`define CVPI_VAL_MAX 10'h0ff
`define CVPI_TEN 10'h00a

// ==========================================================
// Lamp masks, one bit per tick, sixteen ticks a period
`define CVPI_M_OFF 16'h0000
`define CVPI_M_SHORT 16'h0101
`define CVPI_M_DOUBLE 16'h0005
`define CVPI_M_STEADY 16'hffff
`define CVPI_M_SLOW 16'h00ff
`define CVPI_M_LS 16'h0017
`define CVPI_M_LSS 16'h0057
`define CVPI_M_LSSS 16'h0157

// ==========================================================
// Service register and page translation
`define CVPI_PAGE_RST 8'h01
`define CVPI_REG_CV29 3'h4
`define CVPI_REG_PAGE 3'h5
`define CVPI_CV29 10'h01d

`endif

// File: cvpi_pkg.sv
// Types of the config_variable programming interpreter
package cvpi_pkg;

  // ========================================================
  // Keypad procedure states, Gray along the usual path
  typedef enum logic [2:0] {
    CVPI_KP_NORMAL = 3'h0,
    CVPI_KP_S_NUM = 3'h1,
    CVPI_KP_S_VAL = 3'h3,
    CVPI_KP_L_NHI = 3'h2,
    CVPI_KP_L_NLO = 3'h6,
    CVPI_KP_L_VHI = 3'h7,
    CVPI_KP_L_VLO = 3'h5,
    CVPI_KP_SHOW = 3'h4
  } cvpi_kp_t;

  // ========================================================
  // Headlight patterns
  typedef enum logic [2:0] {
    CVPI_FL_OFF = 3'h0,
    CVPI_FL_SHORT = 3'h1,
    CVPI_FL_DOUBLE = 3'h2,
    CVPI_FL_STEADY = 3'h3,
    CVPI_FL_SLOW = 3'h4,
    CVPI_FL_LS = 3'h5,
    CVPI_FL_LSS = 3'h6,
    CVPI_FL_LSSS = 3'h7
  } cvpi_flash_t;

  // ========================================================
  // Track programming modes and commands
  typedef enum logic [1:0] {
    CVPI_DM_DIRECT = 2'h0,
    CVPI_DM_REGISTER = 2'h1,
    CVPI_DM_PAGED = 2'h2,
    CVPI_DM_MAIN = 2'h3
  } cvpi_dmode_t;

  typedef enum logic [1:0] {
    CVPI_DC_WR_BYTE = 2'h0,
    CVPI_DC_VFY_BYTE = 2'h1,
    CVPI_DC_WR_BIT = 2'h2,
    CVPI_DC_VFY_BIT = 2'h3
  } cvpi_dcmd_t;

endpackage

// File: cvpi_flash.sv
// Headlight pattern generator for keypad programming
`timescale 1ns/10ps
`include "cvpi_regs.svh"

module cvpi_flash #(
  parameter int unsigned TICK_CYC = `CVPI_TICK_CYC
) (
  input wire logic clock, // Core clock
  input wire logic rst_n, // Async reset, active low
  input wire cvpi_pkg::cvpi_flash_t pattern, // Selected pattern
  input wire logic restart, // Restart pattern from tick 0
  output logic lamp, // Headlight drive
  output logic done // Pulse at end of a one-shot
);
  import cvpi_pkg::*;

  typedef struct packed {
    logic [23:0] cnt;
    logic [3:0] idx;
    logic stop;
    logic lamp;
    logic done;
  } cvpi_fl_st_t;

  cvpi_fl_st_t s_q, s_d;
  logic [15:0] mask;
  logic one_shot;

  // ========================================================
  // Mask lookup
  always_comb begin
    one_shot = 1'b0;
    unique case (pattern)
      CVPI_FL_OFF: mask = `CVPI_M_OFF;
      CVPI_FL_SHORT: mask = `CVPI_M_SHORT;
      CVPI_FL_DOUBLE: begin
        mask = `CVPI_M_DOUBLE;
        one_shot = 1'b1;
      end
      CVPI_FL_STEADY: begin
        mask = `CVPI_M_STEADY;
        one_shot = 1'b1;
      end
      CVPI_FL_SLOW: mask = `CVPI_M_SLOW;
      CVPI_FL_LS: mask = `CVPI_M_LS;
      CVPI_FL_LSS: mask = `CVPI_M_LSS;
      CVPI_FL_LSSS: mask = `CVPI_M_LSSS;
    endcase
  end

  // ========================================================
  // Tick counter and lamp step
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (restart) begin
      s_d.cnt = 24'h000000;
      s_d.idx = 4'h0;
      s_d.stop = 1'b0;
    end else if (!s_q.stop) begin
      if (s_q.cnt == 24'(TICK_CYC - 1)) begin
        s_d.cnt = 24'h000000;
        s_d.idx = s_q.idx + 4'h1;
        // One-shots halt after one period
        if (one_shot && s_q.idx == 4'hf) begin
          s_d.stop = 1'b1;
          s_d.done = 1'b1;
        end
      end else begin
        s_d.cnt = s_q.cnt + 24'h000001;
      end
    end
    s_d.lamp = !s_d.stop && mask[s_d.idx];
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign lamp = s_q.lamp;
  assign done = s_q.done;
endmodule

// File: cvpi_store.sv
// Config store model beside the programming interpreter
`timescale 1ns/10ps
module cvpi_store (
  input wire logic clock, // Core clock
  input wire logic rst_n, // Async reset, active low
  input wire logic cv_wr_en, // Write pulse
  input wire logic [9:0] cv_wr_num, // Write number
  input wire logic [7:0] cv_wr_data, // Write byte
  input wire logic cv_rd_en, // Read pulse
  input wire logic [9:0] cv_rd_num, // Read number
  output logic [7:0] cv_rd_data // Read byte, one cycle late
);
  logic [7:0] mem [0:1023];

  // ========================================================
  // Store a written byte
  always @(posedge clock) begin
    if (cv_wr_en) begin
      mem[cv_wr_num] <= cv_wr_data;
    end
  end

  // Read one cycle late; stale data inverted so it is never reused
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cv_rd_data <= 8'h00;
    end else if (cv_rd_en) begin
      cv_rd_data <= mem[cv_rd_num];
    end else begin
      cv_rd_data <= ~cv_rd_data;
    end
  end
endmodule

// File: cvpi_chk.sv
// Assertion checker of the programming interpreter ports
`timescale 1ns/10ps
module cvpi_chk (
  input wire logic clock, // Core clock
  input wire logic rst_n, // Async reset, active low
  input wire logic track_power, // Track voltage pin
  input wire logic [13:0] own_addr, // Own address
  input wire logic dcc_valid, // Track command pulse
  input wire cvpi_pkg::cvpi_dmode_t dcc_mode, // Mode
  input wire cvpi_pkg::cvpi_dcmd_t dcc_cmd, // Command kind
  input wire logic [13:0] dcc_addr, // Main address
  input wire logic [9:0] dcc_num, // Variable number
  input wire logic [7:0] dcc_data, // Byte operand
  input wire logic kp_dir_change, // Confirmation pulse
  input wire logic cv_wr_en, // Store write pulse
  input wire logic [9:0] cv_wr_num, // Store write number
  input wire logic [7:0] cv_wr_data, // Store write byte
  input wire logic cv_rd_en, // Store read pulse
  input wire logic svc_ack, // Service acknowledge
  input wire logic kp_active // Keypad mode level
);
  import cvpi_pkg::*;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // ========================================================
  // Track commands
  sequence direct_wr_s;
    dcc_valid && !kp_active && !cv_rd_en && !$past(cv_rd_en) &&
    dcc_mode == CVPI_DM_DIRECT && dcc_cmd == CVPI_DC_WR_BYTE;
  endsequence

  byte_write_a: assert property (
    direct_wr_s |=> cv_wr_en && cv_wr_num == $past(dcc_num) &&
    cv_wr_data == $past(dcc_data))
    else $error("direct byte write not issued");
  service_ack_a: assert property (direct_wr_s |=> svc_ack)
    else $error("service write not acknowledged");
  main_foreign_a: assert property (
    dcc_valid && !cv_rd_en && !$past(cv_rd_en) &&
    dcc_mode == CVPI_DM_MAIN &&
    dcc_addr != own_addr |=> !cv_wr_en && !cv_rd_en)
    else $error("foreign main command acted on");
  main_noread_a: assert property (
    dcc_valid && dcc_mode == CVPI_DM_MAIN &&
    (dcc_cmd == CVPI_DC_VFY_BYTE || dcc_cmd == CVPI_DC_VFY_BIT)
    |=> !cv_rd_en)
    else $error("main verify read the store");

  // ========================================================
  // Keypad procedure
  keypad_block_a: assert property (
    kp_active && dcc_valid |=> !cv_rd_en && !svc_ack)
    else $error("track command served in keypad mode");
  keypad_write_a: assert property (
    cv_wr_en && kp_active |-> $past(kp_dir_change))
    else $error("keypad write without confirmation");
  power_exit_a: assert property (
    $fell(track_power) |-> ##[1:6] !kp_active)
    else $error("keypad mode kept after power loss");
  keypad_enter_a: assert property (
    $rose(kp_active) |-> $past(track_power, 2) && $past(track_power, 3))
    else $error("keypad mode entered without power");

  cover property (svc_ack);
  cover property (cv_wr_en && kp_active);
  cover property ($fell(kp_active));
endmodule

bind cvpi_interpreter cvpi_chk u_cvpi_chk (
  .clock(clock), .rst_n(rst_n), .track_power(track_power),
  .own_addr(own_addr), .dcc_valid(dcc_valid), .dcc_mode(dcc_mode),
  .dcc_cmd(dcc_cmd), .dcc_addr(dcc_addr), .dcc_num(dcc_num),
  .dcc_data(dcc_data), .kp_dir_change(kp_dir_change),
  .cv_wr_en(cv_wr_en), .cv_wr_num(cv_wr_num), .cv_wr_data(cv_wr_data),
  .cv_rd_en(cv_rd_en), .svc_ack(svc_ack), .kp_active(kp_active));

// File: testbench.sv
// Self-checking testbench of the programming interpreter
`timescale 1ns/10ps
module testbench;
  import cvpi_pkg::*;

  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic track_power = 1'b1;
  logic [13:0] own_addr = 14'h0032;
  logic dcc_valid = 1'b0;
  cvpi_dmode_t dcc_mode = CVPI_DM_DIRECT;
  cvpi_dcmd_t dcc_cmd = CVPI_DC_WR_BYTE;
  logic [13:0] dcc_addr = 14'h0000;
  logic [9:0] dcc_num = 10'h000;
  logic [7:0] dcc_data = 8'h00;
  logic [2:0] dcc_bit_pos = 3'h0;
  logic dcc_bit_val = 1'b0;
  logic kp_word_valid = 1'b0;
  logic [6:0] kp_word = 7'h01;
  logic kp_dir_held = 1'b0;
  logic kp_dir_change = 1'b0;
  logic [7:0] cv_rd_data;
  logic cv_wr_en, cv_rd_en, svc_ack, kp_active, lamp;
  logic [9:0] cv_wr_num, cv_rd_num, last_num;
  logic [7:0] cv_wr_data, last_data;
  int failures = 0;
  int samples_checked = 0;
  int wr_cnt = 0, rd_cnt = 0, ack_cnt = 0, w0, r0, a0, cyc = 0;

  cvpi_interpreter #(.TICK_CYC(4)) u_cvpi_interpreter (
    .clock(clock), .rst_n(rst_n), .track_power(track_power),
    .own_addr(own_addr), .dcc_valid(dcc_valid), .dcc_mode(dcc_mode),
    .dcc_cmd(dcc_cmd), .dcc_addr(dcc_addr), .dcc_num(dcc_num),
    .dcc_data(dcc_data), .dcc_bit_pos(dcc_bit_pos),
    .dcc_bit_val(dcc_bit_val), .kp_word_valid(kp_word_valid),
    .kp_word(kp_word), .kp_dir_held(kp_dir_held),
    .kp_dir_change(kp_dir_change), .cv_rd_data(cv_rd_data),
    .cv_wr_en(cv_wr_en), .cv_wr_num(cv_wr_num), .cv_wr_data(cv_wr_data),
    .cv_rd_en(cv_rd_en), .cv_rd_num(cv_rd_num), .svc_ack(svc_ack),
    .kp_active(kp_active), .lamp(lamp));

  cvpi_store u_cvpi_store (
    .clock(clock), .rst_n(rst_n), .cv_wr_en(cv_wr_en),
    .cv_wr_num(cv_wr_num), .cv_wr_data(cv_wr_data), .cv_rd_en(cv_rd_en),
    .cv_rd_num(cv_rd_num), .cv_rd_data(cv_rd_data));

  // ========================================================
  // Clock, pulse counters and hang limit
  always #2 clock = ~clock;

  always @(posedge clock) begin
    cyc++;
    if (svc_ack === 1'b1) ack_cnt++;
    if (cv_rd_en === 1'b1) rd_cnt++;
    if (cv_wr_en === 1'b1) begin
      wr_cnt++;
      last_num = cv_wr_num;
      last_data = cv_wr_data;
    end
    if (cyc == 6000) begin
      failures++;
      complete_run();
    end
  end

  // ========================================================
  // Shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic mark;
    w0 = wr_cnt;
    r0 = rd_cnt;
    a0 = ack_cnt;
  endtask

  task automatic outcome(input int nw, input int nr, input int na,
                         input logic [9:0] num, input logic [7:0] data);
    chk(16'(wr_cnt - w0), 16'(nw), "write count");
    chk(16'(rd_cnt - r0), 16'(nr), "read count");
    chk(16'(ack_cnt - a0), 16'(na), "ack count");
    if (nw > 0) begin
      chk({6'h00, last_num}, {6'h00, num}, "write number");
      chk({8'h00, last_data}, {8'h00, data}, "write data");
    end
  endtask

  task automatic dcc(input cvpi_dmode_t m, input cvpi_dcmd_t c,
                     input logic [13:0] a, input logic [9:0] n,
                     input logic [7:0] d, input logic [2:0] p);
    mark();
    @(negedge clock);
    dcc_valid = 1'b1;
    dcc_mode = m;
    dcc_cmd = c;
    dcc_addr = a;
    dcc_num = n;
    dcc_data = d;
    dcc_bit_pos = p;
    dcc_bit_val = d[0];
    @(negedge clock);
    dcc_valid = 1'b0;
    repeat (4) @(negedge clock);
  endtask

  task automatic kp_entry(input logic [6:0] w);
    @(negedge clock);
    kp_word_valid = 1'b1;
    kp_word = w;
    @(negedge clock);
    kp_word_valid = 1'b0;
  endtask

  task automatic kp_confirm;
    @(negedge clock);
    kp_dir_change = 1'b1;
    @(negedge clock);
    kp_dir_change = 1'b0;
    repeat (4) @(negedge clock);
  endtask

  task automatic kp_send(input logic [6:0] w);
    mark();
    kp_entry(w);
    kp_confirm();
  endtask

  task automatic kp_arm(input logic [6:0] w);
    track_power = 1'b0;
    repeat (8) @(negedge clock);
    kp_dir_held = 1'b1;
    kp_entry(w);
    track_power = 1'b1;
    repeat (10) @(negedge clock);
    kp_dir_held = 1'b0;
  endtask

  // Lit cycles over one 64-cycle pattern period
  task automatic lamp_chk(input int exp);
    int n;
    n = 0;
    repeat (64) @(posedge clock) if (lamp === 1'b1) n++;
    @(negedge clock);
    chk(16'(n), 16'(exp), "lamp cycles");
  endtask

  // ========================================================
  // Scenarios
  task automatic test_service;
    dcc(CVPI_DM_DIRECT, CVPI_DC_WR_BYTE, 14'h0, 10'h003, 8'h07, 3'h0);
    outcome(1, 0, 1, 10'h003, 8'h07);
    dcc(CVPI_DM_REGISTER, CVPI_DC_WR_BYTE, 14'h0, 10'h004, 8'h06, 3'h0);
    outcome(1, 0, 1, 10'h01d, 8'h06);
    dcc(CVPI_DM_PAGED, CVPI_DC_WR_BYTE, 14'h0, 10'h005, 8'h03, 3'h0);
    outcome(0, 0, 1, 10'h000, 8'h00);
    dcc(CVPI_DM_PAGED, CVPI_DC_WR_BYTE, 14'h0, 10'h000, 8'h09, 3'h0);
    outcome(1, 0, 1, 10'h009, 8'h09);
    dcc(CVPI_DM_REGISTER, CVPI_DC_WR_BIT, 14'h0, 10'h000, 8'h01, 3'h1);
    outcome(0, 0, 0, 10'h000, 8'h00);
  endtask

  task automatic test_main;
    dcc(CVPI_DM_MAIN, CVPI_DC_WR_BYTE, 14'h0032, 10'h003, 8'h21, 3'h0);
    outcome(1, 0, 0, 10'h003, 8'h21);
    dcc(CVPI_DM_MAIN, CVPI_DC_WR_BYTE, 14'h0033, 10'h003, 8'h22, 3'h0);
    outcome(0, 0, 0, 10'h000, 8'h00);
    dcc(CVPI_DM_MAIN, CVPI_DC_VFY_BYTE, 14'h0032, 10'h003, 8'h21, 3'h0);
    outcome(0, 0, 0, 10'h000, 8'h00);
  endtask

  task automatic test_readback;
    dcc(CVPI_DM_DIRECT, CVPI_DC_VFY_BYTE, 14'h0, 10'h00a, 8'h5a, 3'h0);
    outcome(0, 1, 1, 10'h000, 8'h00);
    dcc(CVPI_DM_DIRECT, CVPI_DC_VFY_BYTE, 14'h0, 10'h00a, 8'h5b, 3'h0);
    outcome(0, 1, 0, 10'h000, 8'h00);
    dcc(CVPI_DM_DIRECT, CVPI_DC_WR_BIT, 14'h0, 10'h00a, 8'h01, 3'h0);
    outcome(1, 1, 1, 10'h00a, 8'h5b);
    dcc(CVPI_DM_DIRECT, CVPI_DC_VFY_BIT, 14'h0, 10'h00a, 8'h00, 3'h7);
    outcome(0, 1, 1, 10'h000, 8'h00);
    dcc(CVPI_DM_DIRECT, CVPI_DC_VFY_BIT, 14'h0, 10'h00a, 8'h01, 3'h2);
    outcome(0, 1, 0, 10'h000, 8'h00);
  endtask

  task automatic test_short;
    kp_arm(7'h50);
    chk({15'h0, kp_active}, 16'h1, "short entered");
    lamp_chk(8);
    mark();
    kp_confirm();
    outcome(0, 0, 0, 10'h000, 8'h00);
    chk({15'h0, kp_active}, 16'h1, "bare confirm");
    kp_send(7'h03);
    kp_send(7'h50);
    outcome(1, 0, 0, 10'h003, 8'h00);
    chk({15'h0, lamp}, 16'h1, "steady lamp");
    repeat (80) @(negedge clock);
    dcc(CVPI_DM_DIRECT, CVPI_DC_VFY_BYTE, 14'h0, 10'h00a, 8'h5b, 3'h0);
    outcome(0, 0, 0, 10'h000, 8'h00);
    kp_send(7'h50);
    chk({15'h0, kp_active}, 16'h0, "short left");
  endtask

  task automatic test_long;
    kp_arm(7'h32);
    kp_send(7'h07);
    kp_send(7'h07);
    outcome(0, 0, 0, 10'h000, 8'h00);
    repeat (80) @(negedge clock);
    lamp_chk(32);
    kp_send(7'h0c);
    lamp_chk(16);
    kp_send(7'h04);
    lamp_chk(20);
    kp_send(7'h0d);
    lamp_chk(24);
    kp_send(7'h05);
    outcome(1, 0, 0, 10'h07c, 8'h87);
    repeat (80) @(negedge clock);
    kp_send(7'h19);
    kp_send(7'h06);
    kp_send(7'h19);
    kp_send(7'h06);
    outcome(0, 0, 0, 10'h000, 8'h00);
    kp_send(7'h05);
    outcome(1, 0, 0, 10'h100, 8'hff);
    repeat (80) @(negedge clock);
    chk({15'h0, kp_active}, 16'h1, "long kept");
    track_power = 1'b0;
    repeat (8) @(negedge clock);
    chk({15'h0, kp_active}, 16'h0, "long left");
  endtask

  task automatic complete_run;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    u_cvpi_store.mem[10] = 8'h5a;
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    test_service();
    test_main();
    test_readback();
    test_short();
    test_long();
    complete_run();
  end
endmodule
